//--- dmia_core.sv
`include "dmia_consts.svh"
`default_nettype none
module dmia_core #(
    // Width of the program counter output; the counter keeps twelve bits and only its low byte is mapped as a register.
    parameter int PC_WIDTH = 12
) (
    // Clock and asynchronous active-low reset.
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // One request per instruction cycle from the execution core, and its fetch step.
    input  wire dmia_pkg::dmia_req_t req,
    input  wire logic              advance,
    // Read data from the sectored data RAM, valid in the same cycle as its strobe.
    input  wire logic [7:0]        ram_rdata,
    // Stall back to the execution core; low only in the dummy cycle of a jump.
    output logic                   ready,
    // Registered access to the sectored data RAM.
    output dmia_pkg::dmia_ram_t    ram,
    // Registered read answer and the registers this block exposes.
    output logic [7:0]             rdata,
    output logic                   rdata_valid,
    output logic [7:0]             acc,
    output logic [PC_WIDTH-1:0]    pc,
    output logic                   dummy_cycle
);
    ////////////////////////////////////////////////////////////////////////////
    // State and next state.
    // The block sits between the execution core and the sectored data RAM.
    // Each taken request is resolved to a sector and an offset in the cycle in
    // which it stands. The pointers, the program counter low byte and the
    // accumulator are held here; every other location except the three ports lives in the RAM.
    // All outputs come from the state register, so the RAM sees one cycle of latency
    // on every access and a read answer reaches the execution core two cycles after the
    // request. That latency was accepted to keep the address decode out of the RAM timing path.
    // The whole state is one packed struct, so reset and next state stay in step.
    // A user who adds a register here must also add it to the local decode.
    // Otherwise the new offset would silently fall through to the RAM.
    dmia_pkg::dmia_state_t s_q;   // Registered state.
    dmia_pkg::dmia_state_t s_d;   // Next state.
    logic [7:0]  eff_sector;      // Resolved target sector.
    logic [7:0]  eff_offset;      // Resolved target offset.
    logic        is_port;         // Operand names an indirect port.
    logic        tgt_port;        // Resolved target is itself a port.
    logic        tgt_local;       // Resolved target is held in this block.
    logic [7:0]  local_rd;        // Value of a locally held location.
    logic [7:0]  wval;            // Value to be stored by a write.
    ////////////////////////////////////////////////////////////////////////////
    // Address resolution for direct, extended and indirect operands.
    // The decode looks at the offset only, so an extended operand that names a
    // port offset in any sector still goes through that port. The RAM byte behind
    // such an offset in another sector cannot be reached; the special area
    // shadows it in every sector.
    always_comb begin
        // A plain instruction addresses sector zero; an extended one uses the full address.
        eff_sector = req.extended ? req.sector : `DMIA_SECTOR_ZERO;
        eff_offset = req.offset;
        is_port    = 1'b0;
        // Special registers are decoded by offset only, so they appear in every sector.
        case (req.offset)
            `DMIA_ADDR_PORT_S0: begin
                // The first port is locked to sector zero whatever the operand says.
                is_port    = 1'b1;
                eff_sector = `DMIA_SECTOR_ZERO;
                eff_offset = s_q.ptr_s0;
            end
            `DMIA_ADDR_PORT_A: begin
                // The sector byte of the first pointer pair selects the sector.
                is_port    = 1'b1;
                eff_sector = s_q.ptr_a_sec;
                eff_offset = s_q.ptr_a_low;
            end
            `DMIA_ADDR_PORT_B: begin
                // The sector byte of the second pointer pair selects the sector.
                is_port    = 1'b1;
                eff_sector = s_q.ptr_b_sec;
                eff_offset = s_q.ptr_b_low;
            end
            default: begin
                // A direct operand addresses the location that it names.
                is_port = 1'b0;
            end
        endcase
        // A pointer that aims at a port location leads nowhere.
        tgt_port  = (eff_offset == `DMIA_ADDR_PORT_S0) || (eff_offset == `DMIA_ADDR_PORT_A)
                 || (eff_offset == `DMIA_ADDR_PORT_B);
        // Offsets from the first pointer up to the accumulator live in this block.
        tgt_local = (eff_offset >= `DMIA_ADDR_PTR_S0) && (eff_offset <= `DMIA_ADDR_ACC)
                 && !tgt_port;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Read mux for the registers this block keeps itself.
    // The value is captured when the read is taken, so a write to the same
    // register in the next cycle does not disturb the answer.
    // The mux is driven by the resolved offset, so port reads reach it as well.
    always_comb begin
        case (eff_offset)
            `DMIA_ADDR_PTR_S0:    local_rd = s_q.ptr_s0;
            `DMIA_ADDR_PTR_A_LOW: local_rd = s_q.ptr_a_low;
            `DMIA_ADDR_PTR_A_SEC: local_rd = s_q.ptr_a_sec;
            `DMIA_ADDR_PTR_B_LOW: local_rd = s_q.ptr_b_low;
            `DMIA_ADDR_PTR_B_SEC: local_rd = s_q.ptr_b_sec;
            `DMIA_ADDR_PCL:       local_rd = s_q.pc[7:0];
            `DMIA_ADDR_ACC:       local_rd = s_q.acc;
            // Port offsets have no storage and read as zero.
            default:              local_rd = `DMIA_RST_BYTE;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    // One request is taken per cycle. Strobes and the read-valid pulse default
    // low and are raised for one cycle only: the strobes in the cycle after the
    // request, the read-valid pulse one cycle later. So every RAM access lasts
    // exactly one cycle. A write to the program counter low byte
    // raises the dummy flag; in the next cycle the request is ignored and the
    // fetch does not move, which gives the single dummy cycle of a jump.
    always_comb begin
        s_d = s_q;
        s_d.ram.read_en  = 1'b0;
        s_d.ram.write_en = 1'b0;
        s_d.rdata_valid  = 1'b0;
        // Memory writes only carry the accumulator or an ALU result, never another register.
        wval = (req.op == dmia_pkg::DMIA_OP_ALU_TO_MEM) ? req.alu_result : s_q.acc;
        // Finish a read started in the previous cycle.
        if (s_q.rd_pending) begin
            s_d.rd_pending  = 1'b0;
            s_d.rdata_valid = 1'b1;
            if (s_q.rd_zero) begin
                // A port aimed at a port has no storage behind it.
                s_d.rdata = `DMIA_RST_BYTE;
            end else if (s_q.rd_local) begin
                // A local register was captured when the request was taken.
                s_d.rdata = s_q.rd_local_data;
            end else begin
                // RAM data is valid in this cycle only, so it is taken now.
                s_d.rdata = ram_rdata;
            end
        end
        if (s_q.dummy) begin
            // The dummy cycle takes no request; the fetch restarts afterwards.
            s_d.dummy = 1'b0;
            // Any read finishing in this cycle was handled above, so no answer is lost.
        end else if (req.valid) begin
            case (req.op)
                dmia_pkg::DMIA_OP_READ: begin
                    // Reads of local registers are answered here and never reach the RAM.
                    s_d.rd_pending    = 1'b1;
                    s_d.rd_zero       = is_port && tgt_port;
                    s_d.rd_local      = tgt_local;
                    s_d.rd_local_data = local_rd;
                    s_d.ram.read_en   = !tgt_port && !tgt_local;
                    s_d.ram.sector    = eff_sector;
                    s_d.ram.offset    = eff_offset;
                end
                dmia_pkg::DMIA_OP_ALU_TO_ACC: begin
                    // Results of the arithmetic unit land in the accumulator here; under DMIA_OP_ALU_TO_MEM they go to the operand location.
                    s_d.acc = req.alu_result;
                end
                dmia_pkg::DMIA_OP_WRITE_ACC, dmia_pkg::DMIA_OP_ALU_TO_MEM: begin
                    // A port location holds nothing, so such writes vanish.
                    if (tgt_port) begin
                        s_d.ram.write_en = 1'b0;
                    end else if (tgt_local) begin
                        case (eff_offset)
                            `DMIA_ADDR_PTR_S0:    s_d.ptr_s0    = wval;
                            `DMIA_ADDR_PTR_A_LOW: s_d.ptr_a_low = wval;
                            `DMIA_ADDR_PTR_A_SEC: s_d.ptr_a_sec = wval;
                            `DMIA_ADDR_PTR_B_LOW: s_d.ptr_b_low = wval;
                            `DMIA_ADDR_PTR_B_SEC: s_d.ptr_b_sec = wval;
                            `DMIA_ADDR_ACC:       s_d.acc       = wval;
                            `DMIA_ADDR_PCL: begin
                                // Only the low byte moves, so the jump stays in this page.
                                // The flag holds off the next request for one cycle.
                                s_d.pc[7:0] = wval;
                                s_d.dummy   = 1'b1;
                            end
                            // Unreachable: every local offset is listed above.
                            default: s_d.acc = s_q.acc;
                        endcase
                    end else begin
                        // Every other location is RAM in the resolved sector.
                        s_d.ram.write_en = 1'b1;
                        s_d.ram.sector   = eff_sector;
                        s_d.ram.offset   = eff_offset;
                        s_d.ram.wdata    = wval;
                    end
                end
                default: begin
                    // A request with no operation only lets the fetch move on.
                    s_d.rd_pending = s_d.rd_pending;
                end
            endcase
            // Normal sequential advance unless the program counter was loaded.
            // The dummy flag set above blocks the increment so the new target is kept.
            if (advance && !s_d.dummy) begin
                s_d.pc = s_q.pc + 12'h001;
            end
        end else if (advance) begin
            // No request this cycle; the fetch still moves on.
            s_d.pc = s_q.pc + 12'h001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // State register.
    // The asynchronous reset clears every field, so the pointers, the program
    // counter and the accumulator all start at zero with no request pending.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    // The handshake output is decoded from the register; data outputs are flip-flops.
    // The state keeps twelve program counter bits; the port is sized to the parameter.
    assign ready       = !s_q.dummy;
    assign ram         = s_q.ram;
    assign rdata       = s_q.rdata;
    assign rdata_valid = s_q.rdata_valid;
    assign acc         = s_q.acc;
    assign pc          = PC_WIDTH'(s_q.pc);
    assign dummy_cycle = s_q.dummy;
endmodule : dmia_core
`default_nettype wire

//--- dmia_consts.svh
`ifndef DMIA_CONSTS_SVH
`define DMIA_CONSTS_SVH
// Special register offsets within every sector.
`define DMIA_ADDR_PORT_S0    8'h00
`define DMIA_ADDR_PTR_S0     8'h01
`define DMIA_ADDR_PORT_A     8'h02
`define DMIA_ADDR_PTR_A_LOW  8'h03
`define DMIA_ADDR_PTR_A_SEC  8'h04
`define DMIA_ADDR_PORT_B     8'h05
`define DMIA_ADDR_PTR_B_LOW  8'h06
`define DMIA_ADDR_PTR_B_SEC  8'h07
`define DMIA_ADDR_PCL        8'h08
`define DMIA_ADDR_ACC        8'h09
// Reset values.
`define DMIA_RST_BYTE        8'h00
`define DMIA_SECTOR_ZERO     8'h00
`define DMIA_RST_PC          12'h000
`endif

//--- dmia_pkg.sv
`default_nettype none
package dmia_pkg;
    // Operation requested by the execution core.
    typedef enum logic [2:0] {
        DMIA_OP_NONE,
        DMIA_OP_READ,
        DMIA_OP_WRITE_ACC,
        DMIA_OP_ALU_TO_ACC,
        DMIA_OP_ALU_TO_MEM
    } dmia_op_t;
    // Request from the execution core for one instruction cycle.
    typedef struct packed {
        logic       valid;
        dmia_op_t   op;
        logic       extended;
        logic [7:0] sector;
        logic [7:0] offset;
        logic [7:0] alu_result;
    } dmia_req_t;
    // Access presented to the sectored data RAM.
    typedef struct packed {
        logic       read_en;
        logic       write_en;
        logic [7:0] sector;
        logic [7:0] offset;
        logic [7:0] wdata;
    } dmia_ram_t;
    // Complete state of the block.
    typedef struct packed {
        logic [7:0]  ptr_s0;
        logic [7:0]  ptr_a_low;
        logic [7:0]  ptr_a_sec;
        logic [7:0]  ptr_b_low;
        logic [7:0]  ptr_b_sec;
        logic [7:0]  acc;
        logic [11:0] pc;
        logic        dummy;
        logic        rd_pending;
        logic        rd_zero;
        logic        rd_local;
        logic [7:0]  rd_local_data;
        logic [7:0]  rdata;
        logic        rdata_valid;
        dmia_ram_t   ram;
    } dmia_state_t;
endpackage : dmia_pkg
`default_nettype wire

//--- dmia_core_chk.sv
`include "dmia_consts.svh"
`default_nettype none
module dmia_core_chk #(
    parameter int PC_WIDTH = 12
) (
    input wire logic                mclk,
    input wire logic                rst_n,
    input wire dmia_pkg::dmia_req_t req,
    input wire logic                advance,
    input wire logic [7:0]          ram_rdata,
    input wire logic                ready,
    input wire dmia_pkg::dmia_ram_t ram,
    input wire logic [7:0]          rdata,
    input wire logic                rdata_valid,
    input wire logic [7:0]          acc,
    input wire logic [PC_WIDTH-1:0] pc,
    input wire logic                dummy_cycle
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic take;  // A request is only taken while the core is not stalled.
    assign take = req.valid && ready;
    ////////////////////////////////////////////////////////////////////////////////
    sequence pcl_write_s;
        take && !req.extended && req.op == dmia_pkg::DMIA_OP_WRITE_ACC
            && req.offset == `DMIA_ADDR_PCL;
    endsequence
    sequence stall_s;
        dummy_cycle && !ready;
    endsequence
    alu_to_acc_a: assert property (take && req.op == dmia_pkg::DMIA_OP_ALU_TO_ACC
        |=> acc == $past(req.alu_result)) else $error("acc missed alu result");
    ext_addr_a: assert property (take && req.extended && req.op == dmia_pkg::DMIA_OP_READ
        && req.offset > `DMIA_ADDR_ACC
        |=> ram.read_en && ram.sector == $past(req.sector) && ram.offset == $past(req.offset))
        else $error("extended address split wrong");
    read_answer_a: assert property (ram.read_en |=> rdata_valid)
        else $error("read answer missing");
    pcl_jump_a: assert property (pcl_write_s |=> pc[7:0] == $past(acc))
        else $error("pc low byte not loaded");
    page_keep_a: assert property (pcl_write_s |=> (pc >> 8) == ($past(pc) >> 8))
        else $error("pc page changed");
    dummy_insert_a: assert property (pcl_write_s |=> stall_s ##1 !dummy_cycle && ready)
        else $error("dummy cycle wrong");
    stall_ignore_a: assert property (req.valid && !ready |=> !ram.read_en && !ram.write_en)
        else $error("request taken during dummy");
    acc_only_a: assert property (ram.write_en
        |-> ram.wdata == $past(acc) || ram.wdata == $past(req.alu_result))
        else $error("memory written from non accumulator source");
endmodule : dmia_core_chk
bind dmia_core dmia_core_chk #(.PC_WIDTH(PC_WIDTH)) chk_i (.mclk(mclk), .rst_n(rst_n),
    .req(req), .advance(advance), .ram_rdata(ram_rdata), .ready(ready), .ram(ram),
    .rdata(rdata), .rdata_valid(rdata_valid), .acc(acc), .pc(pc), .dummy_cycle(dummy_cycle));
`default_nettype wire

//--- dmia_ram_model.sv
`default_nettype none
module dmia_ram_model (
    input  wire logic                mclk,
    input  wire dmia_pkg::dmia_ram_t ram,
    output logic [7:0]               ram_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [65536];    // Indexed by sector and offset together.
    logic [7:0] last_q = 8'h00; // Last byte read out.
    logic       hold_q = 1'b0;  // Set for the one cycle that read data is held.
    initial foreach (mem[i]) mem[i] = 8'h00;
    // Outside the hold cycle the bus toggles, so stale data can never pass for a match.
    assign ram_rdata = ram.read_en ? mem[{ram.sector, ram.offset}] : (hold_q ? last_q : ~last_q);
    always @(posedge mclk) begin
        if (ram.write_en) mem[{ram.sector, ram.offset}] <= ram.wdata;
        hold_q <= ram.read_en;
        last_q <= ram.read_en ? mem[{ram.sector, ram.offset}] : (hold_q ? last_q : ~last_q);
    end
endmodule : dmia_ram_model
`default_nettype wire

//--- data_memory_indirect_addressing_tb_top.sv
`default_nettype none
module data_memory_indirect_addressing_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_n, advance, ready, rdata_valid, dummy_cycle;
    logic [7:0] ram_rdata, rdata, acc;
    logic [11:0] pc;
    dmia_pkg::dmia_req_t req;
    dmia_pkg::dmia_ram_t ram;
    int mismatches = 0;
    int checks = 0;
    dmia_core uut (.mclk(mclk), .rst_n(rst_n), .req(req), .advance(advance),
        .ram_rdata(ram_rdata), .ready(ready), .ram(ram), .rdata(rdata),
        .rdata_valid(rdata_valid), .acc(acc), .pc(pc), .dummy_cycle(dummy_cycle));
    dmia_ram_model ram_i (.mclk(mclk), .ram(ram), .ram_rdata(ram_rdata));
    initial forever #10 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    // Called at a falling edge; holds the request until a rising edge takes it.
    task automatic op(input dmia_pkg::dmia_op_t o, input logic x, input logic [7:0] s, f, a);
        int n;
        req = '{1'b1, o, x, s, f, a};
        n = 0;
        while (ready !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 20) begin
            mismatches++;
            $display("[FAIL] %0t request never taken", $time);
        end
        @(negedge mclk);
    endtask : op
    task automatic idle(input int n);
        req.valid = 1'b0;
        repeat (n) @(negedge mclk);
    endtask : idle
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        if (mismatches == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    // Through the accumulator only, since memory to memory moves do not exist.
    task automatic put(input logic [7:0] where, input logic [7:0] v);
        op(dmia_pkg::DMIA_OP_ALU_TO_ACC, 1'b0, 8'h00, 8'h00, v);
        op(dmia_pkg::DMIA_OP_WRITE_ACC, 1'b0, 8'h00, where, 8'h00);
    endtask : put
    initial begin
        repeat (2000) @(posedge mclk);
        mismatches++;
        print_verdict();
    end
    initial begin
        req = '0;
        advance = 1'b0;
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        put(8'h03, 8'h40);
        put(8'h04, 8'h01);
        put(8'h02, 8'hA5);
        idle(3);
        chk(ram_i.mem[16'h0140], 8'hA5);
        op(dmia_pkg::DMIA_OP_READ, 1'b0, 8'h00, 8'h03, 8'h00);
        idle(3);
        chk(rdata, 8'h40);
        op(dmia_pkg::DMIA_OP_READ, 1'b0, 8'h00, 8'h02, 8'h00);
        idle(3);
        chk(rdata, 8'hA5);
        put(8'h01, 8'h30);
        // The first port must stay in sector zero even under an extended operand.
        op(dmia_pkg::DMIA_OP_ALU_TO_MEM, 1'b1, 8'h01, 8'h00, 8'h3C);
        op(dmia_pkg::DMIA_OP_ALU_TO_MEM, 1'b1, 8'h01, 8'hF0, 8'h6E);
        op(dmia_pkg::DMIA_OP_READ, 1'b1, 8'h01, 8'hF0, 8'h00);
        idle(3);
        chk(ram_i.mem[16'h0030], 8'h3C);
        chk(rdata, 8'h6E);
        put(8'h01, 8'h00);
        op(dmia_pkg::DMIA_OP_ALU_TO_MEM, 1'b0, 8'h00, 8'h00, 8'hFF);
        op(dmia_pkg::DMIA_OP_READ, 1'b0, 8'h00, 8'h00, 8'h00);
        idle(3);
        chk(rdata, 8'h00);
        chk(ram_i.mem[16'h0000], 8'h00);
        advance = 1'b1;
        repeat (300) @(negedge mclk);
        advance = 1'b0;
        put(8'h08, 8'h77);
        chk(dummy_cycle, 1'b1);
        op(dmia_pkg::DMIA_OP_READ, 1'b0, 8'h00, 8'h09, 8'h00);
        idle(3);
        chk(rdata, 8'h77);
        chk(pc, 12'h177);
        // A mid-run reset clears the core, and a request may follow at once.
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        chk(acc, 8'h00);
        chk(pc, 12'h000);
        put(8'h06, 8'h5A);
        op(dmia_pkg::DMIA_OP_READ, 1'b0, 8'h00, 8'h06, 8'h00);
        idle(3);
        chk(rdata, 8'h5A);
        print_verdict();
    end
endmodule : data_memory_indirect_addressing_tb_top
`default_nettype wire
